/* File: src/sofs_defines.svh */
// Offsets, field positions, reset values and frame constants.
// Included by the framer top; no logic.
`ifndef SOFS_DEFINES_SVH
`define SOFS_DEFINES_SVH
`define SOFS_OFF_CTRL 12'h000
`define SOFS_OFF_LANE_EN 12'h004
`define SOFS_OFF_BYPASS 12'h008
`define SOFS_OFF_STATUS 12'h00c
`define SOFS_OFF_ALARM 12'h010
`define SOFS_B_AUTOMATIC_OVERHEAD_INSERT 0
`define SOFS_B_AUTOMATIC_SECTION_OVERHEAD_INSERT 1
`define SOFS_B_CORR_A 2
`define SOFS_B_CORR_B1 3
`define SOFS_B_INJ_K2 4
`define SOFS_B_BIP_EN 5
`define SOFS_B_OOF_EN 6
`define SOFS_B_RDI_EN 7
`define SOFS_B_AIS_EN 8
`define SOFS_B_GRP 9
`define SOFS_B_REALIGN 11
`define SOFS_CTRL_W 11
`define SOFS_CTRL_RST 11'h1e0
`define SOFS_LANE_EN_RST 1'b1
`define SOFS_BYPASS_RST 1'b0
`define SOFS_ALM_OOF 0
`define SOFS_ALM_B1 8
`define SOFS_ALM_FE 16
`define SOFS_ALM_RDI 24
`define SOFS_A1 8'hf6
`define SOFS_A2 8'h28
`define SOFS_K2_FAULT 8'h06
`define SOFS_RDI_CODE 3'h6
`define SOFS_SCR_SEED 7'h7f
`define SOFS_ROWS 9
`define SOFS_SOH_ROWS 3
`define SOFS_B1_ROW 1
`define SOFS_K2_ROW 4
`define SOFS_K2_WORD 24
`define SOFS_A2_WORD 12
`define SOFS_A_END 24
`define SOFS_OOF_MISS 4
`endif

/* File: src/sofs_pkg.sv */
// Types shared by the framer/scrambler block.
// Assumes sofs_defines.svh supplies the numeric constants.
package sofs_pkg;
    typedef enum logic [1:0] {
        SOFS_OOF = 2'b01,
        SOFS_INF = 2'b10
    } sofs_frm_e;
    typedef struct packed {
        logic fp;
        logic spe;
        logic [31:0] data;
    } sofs_rxw_s;
endpackage : sofs_pkg

/* File: src/sofs_top.sv */
// Overhead insert, scrambler, framer, descrambler and lane deskew.
// Assumes one clock; line words come from same-clock mux/demux logic.
//
// Functional notes
// - Transmit handles 144 overhead bytes per row
// - Overhead from fabric or generated in auto mode
// - Framing corruption inverts A1 and A2 bytes
// - Parity error request inverts transmitted B1 byte
// - Fault injection forces K2 to 00000110
// - Receive flags corrupted framing, parity, fault bytes
// - Receive gives aligned 32-bit words, one-cycle pulse
// - Tracks in/out of frame, alarms on out-of-frame
// - Transmit scrambles with 1 + x^6 + x^7
// - Receive descrambles with the same polynomial
// - Lanes independent, paired, quads or all eight
// - Powered-down lane rejoins only if aligned before
// - Framer word-aligns received data before anything else
// - Alignment buffer removes lane skew within group
// - Parity, frame, defect, alarm-insert checks enable-bits
// - Payload envelope indicator beside each receive word
// - Per-lane option bypasses the alignment buffer
// - Word processing rate; words become bytes downstream
`timescale 1ns/1ps
`include "sofs_defines.svh"
module sofs_top import sofs_pkg::*; #(
    parameter int NCH = 8,
    parameter int ROW_WORDS = 1080,
    parameter int TOH_WORDS = 36,
    parameter int DEPTH = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NCH-1:0][31:0] tx_data,
    output logic tx_sof,
    output logic [NCH-1:0][31:0] tx_line,
    input wire logic [NCH-1:0][31:0] rx_line,
    output sofs_rxw_s [NCH-1:0] rx_word,
    output logic [NCH-1:0] rx_vld,
    output logic [NCH-1:0] oof_evt
);
    localparam int CW = $clog2(ROW_WORDS);
    localparam int AW = $clog2(DEPTH);

    function automatic logic [38:0] scr_step(input logic [6:0] s);
        logic [31:0] k;
        logic [6:0] t;
        t = s;
        k = '0;
        for (int b = 31; b >= 0; b--) begin
            k[b] = t[6];
            t = {t[5:0], t[6] ^ t[5]};
        end
        return {k, t};
    endfunction : scr_step

    function automatic logic [CW+3:0] adv(input logic [CW-1:0] c, input logic [3:0] r);
        if (c != CW'(ROW_WORDS - 1))
            return {r, c + CW'(1)};
        return {(r == 4'(`SOFS_ROWS - 1)) ? 4'h0 : r + 4'h1, {CW{1'b0}}};
    endfunction : adv

    function automatic logic [7:0] fold(input logic [31:0] w);
        return w[31:24] ^ w[23:16] ^ w[15:8] ^ w[7:0];
    endfunction : fold

    function automatic logic same_grp(input int a, input int b, input logic [1:0] m);
        case (m)
            2'h0: return a == b;
            2'h1: return (a / 2) == (b / 2);
            2'h2: return (a / 4) == (b / 4);
            default: return 1'b1;
        endcase
    endfunction : same_grp

    // Register file
    logic [`SOFS_CTRL_W-1:0] ctrl_r, ctrl_nxt;
    logic [NCH-1:0] lane_en_r, lane_en_nxt, bypass_r, bypass_nxt;
    logic [31:0] alm_r, alm_nxt, prdata_r, prdata_nxt;
    logic realign_r, realign_nxt;
    logic [NCH-1:0] inf_w, b1_ev, fe_ev, rdi_ev, mbr_r;
    logic wr, hit;
    logic [31:0] w1c, sets;

    always_comb begin
        wr = psel && penable && pwrite;
        hit = paddr inside {`SOFS_OFF_CTRL, `SOFS_OFF_LANE_EN, `SOFS_OFF_BYPASS,
                            `SOFS_OFF_STATUS, `SOFS_OFF_ALARM};
        ctrl_nxt = ctrl_r;
        lane_en_nxt = lane_en_r;
        bypass_nxt = bypass_r;
        realign_nxt = 1'b0;
        w1c = '0;
        if (wr && paddr == `SOFS_OFF_CTRL) begin
            ctrl_nxt = pwdata[`SOFS_CTRL_W-1:0];
            realign_nxt = pwdata[`SOFS_B_REALIGN];
        end
        if (wr && paddr == `SOFS_OFF_LANE_EN)
            lane_en_nxt = pwdata[NCH-1:0];
        if (wr && paddr == `SOFS_OFF_BYPASS)
            bypass_nxt = pwdata[NCH-1:0];
        if (wr && paddr == `SOFS_OFF_ALARM)
            w1c = pwdata;
        sets = '0;
        sets[`SOFS_ALM_OOF +: 8] = 8'(oof_evt & {NCH{ctrl_r[`SOFS_B_OOF_EN]}});
        sets[`SOFS_ALM_B1 +: 8] = 8'(b1_ev);
        sets[`SOFS_ALM_FE +: 8] = 8'(fe_ev);
        sets[`SOFS_ALM_RDI +: 8] = 8'(rdi_ev);
        alm_nxt = (alm_r & ~w1c) | sets;
        prdata_nxt = prdata_r;
        if (psel && !penable) begin
            case (paddr)
                `SOFS_OFF_CTRL: prdata_nxt = 32'(ctrl_r);
                `SOFS_OFF_LANE_EN: prdata_nxt = 32'(lane_en_r);
                `SOFS_OFF_BYPASS: prdata_nxt = 32'(bypass_r);
                `SOFS_OFF_STATUS: prdata_nxt = {16'h0000, 8'(mbr_r), 8'(inf_w)};
                `SOFS_OFF_ALARM: prdata_nxt = alm_r;
                default: prdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= `SOFS_CTRL_RST;
            lane_en_r <= {NCH{`SOFS_LANE_EN_RST}};
            bypass_r <= {NCH{`SOFS_BYPASS_RST}};
            alm_r <= 32'h0000_0000;
            prdata_r <= 32'h0000_0000;
            realign_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            lane_en_r <= lane_en_nxt;
            bypass_r <= bypass_nxt;
            alm_r <= alm_nxt;
            prdata_r <= prdata_nxt;
            realign_r <= realign_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;

    // Transmit frame position and scrambler, common to all lanes
    logic [CW-1:0] tcol_r, tcol_nxt;
    logic [3:0] trow_r, trow_nxt;
    logic [6:0] tscr_r, tscr_nxt;
    logic [31:0] tkey;
    logic ttoh, tlast;

    always_comb begin
        {trow_nxt, tcol_nxt} = adv(tcol_r, trow_r);
        ttoh = tcol_r < CW'(TOH_WORDS);
        tlast = trow_r == 4'(`SOFS_ROWS - 1) && tcol_r == CW'(ROW_WORDS - 1);
        {tkey, tscr_nxt} = scr_step((trow_r == 4'h0 && tcol_r == CW'(TOH_WORDS)) ?
                                    `SOFS_SCR_SEED : tscr_r);
        tx_sof = trow_r == 4'h0 && tcol_r == '0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tcol_r <= '0;
            trow_r <= 4'h0;
            tscr_r <= `SOFS_SCR_SEED;
        end else begin
            tcol_r <= tcol_nxt;
            trow_r <= trow_nxt;
            tscr_r <= tscr_nxt;
        end
    end

    sofs_rxw_s [NCH-1:0] fw_w;
    logic [NCH-1:0] fv_w;

    for (genvar i = 0; i < NCH; i++) begin : g_lane
        // Transmit lane
        logic [31:0] ow, sw, tx_r;
        logic [7:0] tacc_r, tacc_nxt, tbip_r, tbip_nxt;
        logic autom;

        always_comb begin
            autom = ttoh && (ctrl_r[`SOFS_B_AUTOMATIC_OVERHEAD_INSERT] ||
                    (ctrl_r[`SOFS_B_AUTOMATIC_SECTION_OVERHEAD_INSERT] && trow_r < 4'(`SOFS_SOH_ROWS)));
            ow = tx_data[i];
            if (autom) begin
                ow = 32'h0000_0000;
                if (trow_r == 4'h0 && tcol_r < CW'(`SOFS_A2_WORD))
                    ow = {4{`SOFS_A1}};
                else if (trow_r == 4'h0 && tcol_r < CW'(`SOFS_A_END))
                    ow = {4{`SOFS_A2}};
                if (trow_r == 4'(`SOFS_B1_ROW) && tcol_r == '0)
                    ow[31:24] = tbip_r;
            end
            if (ctrl_r[`SOFS_B_CORR_A] && trow_r == 4'h0 && tcol_r < CW'(`SOFS_A_END))
                ow = ~ow;
            if (ctrl_r[`SOFS_B_CORR_B1] && trow_r == 4'(`SOFS_B1_ROW) && tcol_r == '0)
                ow[31:24] = ~ow[31:24];
            if (ctrl_r[`SOFS_B_INJ_K2] && trow_r == 4'(`SOFS_K2_ROW) &&
                tcol_r == CW'(`SOFS_K2_WORD))
                ow[31:24] = `SOFS_K2_FAULT;
            sw = (trow_r == 4'h0 && ttoh) ? ow : ow ^ tkey;
            tacc_nxt = (tx_sof ? 8'h00 : tacc_r) ^ fold(sw);
            tbip_nxt = tlast ? tacc_nxt : tbip_r;
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                tx_r <= 32'h0000_0000;
                tacc_r <= 8'h00;
                tbip_r <= 8'h00;
            end else begin
                tx_r <= sw;
                tacc_r <= tacc_nxt;
                tbip_r <= tbip_nxt;
            end
        end
        assign tx_line[i] = tx_r;

        // Receive framer and descrambler
        sofs_frm_e st_r, st_nxt;
        logic [31:0] p2_r, p1_r, aw, dw;
        logic [95:0] win;
        logic [1:0] off_r, off_nxt, hoff;
        logic [2:0] miss_r, miss_nxt;
        logic [CW-1:0] col_r, col_nxt;
        logic [3:0] row_r, row_nxt;
        logic [6:0] dscr_r, dscr_nxt;
        logic [31:0] key;
        logic [7:0] racc_r, racc_nxt, rbip_r, rbip_nxt;
        logic fhit, rtoh, inf, oev, bev, fev, rev;
        sofs_rxw_s fw_r, fw_nxt;
        logic fv_r, fv_nxt;

        always_comb begin
            win = {p2_r, p1_r, rx_line[i]};
            fhit = 1'b0;
            hoff = 2'h0;
            for (int k = 3; k >= 0; k--) begin
                if (win[95-8*k -: 32] == {`SOFS_A1, `SOFS_A1, `SOFS_A2, `SOFS_A2}) begin
                    fhit = 1'b1;
                    hoff = 2'(k);
                end
            end
            aw = win[7'(79 - 8 * off_r) -: 32];
            st_nxt = st_r;
            off_nxt = off_r;
            miss_nxt = miss_r;
            {row_nxt, col_nxt} = adv(col_r, row_r);
            oev = 1'b0;
            fev = 1'b0;
            case (st_r)
                SOFS_OOF: begin
                    if (fhit) begin
                        st_nxt = SOFS_INF;
                        off_nxt = hoff;
                        miss_nxt = 3'h0;
                        row_nxt = 4'h0;
                        col_nxt = CW'(`SOFS_A2_WORD + 1);
                    end
                end
                SOFS_INF: begin
                    if (row_r == 4'h0 && col_r == CW'(`SOFS_A2_WORD)) begin
                        if (win[7'(95 - 8 * off_r) -: 32] !=
                            {`SOFS_A1, `SOFS_A1, `SOFS_A2, `SOFS_A2}) begin
                            fev = 1'b1;
                            miss_nxt = miss_r + 3'h1;
                            if (miss_r == 3'(`SOFS_OOF_MISS - 1)) begin
                                st_nxt = SOFS_OOF;
                                oev = 1'b1;
                            end
                        end else begin
                            miss_nxt = 3'h0;
                        end
                    end
                end
                default: st_nxt = SOFS_OOF;
            endcase
            inf = st_r == SOFS_INF;
            rtoh = col_r < CW'(TOH_WORDS);
            {key, dscr_nxt} = scr_step((row_r == 4'h0 && col_r == CW'(TOH_WORDS)) ?
                                       `SOFS_SCR_SEED : dscr_r);
            dw = (row_r == 4'h0 && rtoh) ? aw : aw ^ key;
            if (!inf && ctrl_r[`SOFS_B_AIS_EN])
                dw = 32'hffff_ffff;
            racc_nxt = ((row_r == 4'h0 && col_r == '0) ? 8'h00 : racc_r) ^ fold(aw);
            rbip_nxt = (row_r == 4'(`SOFS_ROWS - 1) && col_r == CW'(ROW_WORDS - 1)) ?
                       racc_nxt : rbip_r;
            bev = inf && ctrl_r[`SOFS_B_BIP_EN] && row_r == 4'(`SOFS_B1_ROW) &&
                  col_r == '0 && dw[31:24] != rbip_r;
            rev = inf && ctrl_r[`SOFS_B_RDI_EN] && row_r == 4'(`SOFS_K2_ROW) &&
                  col_r == CW'(`SOFS_K2_WORD) && dw[26:24] == `SOFS_RDI_CODE;
            fw_nxt.fp = inf && row_r == 4'h0 && col_r == '0;
            fw_nxt.spe = inf && !rtoh;
            fw_nxt.data = dw;
            fv_nxt = inf || ctrl_r[`SOFS_B_AIS_EN];
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                st_r <= SOFS_OOF;
                p2_r <= 32'h0000_0000;
                p1_r <= 32'h0000_0000;
                off_r <= 2'h0;
                miss_r <= 3'h0;
                col_r <= '0;
                row_r <= 4'h0;
                dscr_r <= `SOFS_SCR_SEED;
                racc_r <= 8'h00;
                rbip_r <= 8'h00;
                fw_r <= '0;
                fv_r <= 1'b0;
            end else begin
                st_r <= st_nxt;
                p2_r <= p1_r;
                p1_r <= rx_line[i];
                off_r <= off_nxt;
                miss_r <= miss_nxt;
                col_r <= col_nxt;
                row_r <= row_nxt;
                dscr_r <= dscr_nxt;
                racc_r <= racc_nxt;
                rbip_r <= rbip_nxt;
                fw_r <= fw_nxt;
                fv_r <= fv_nxt;
            end
        end
        assign fw_w[i] = fw_r;
        assign fv_w[i] = fv_r;
        assign inf_w[i] = inf;
        assign oof_evt[i] = oev;
        assign b1_ev[i] = bev;
        assign fe_ev[i] = fev;
        assign rdi_ev[i] = rev;
    end

    // Deskew buffers, shared write pointer
    sofs_rxw_s mem [NCH][DEPTH];
    logic [AW-1:0] wp_r, fs_r[NCH], fs_nxt[NCH], rp_r[NCH], rp_nxt[NCH];
    logic [AW-1:0] dly_r[NCH], dly_nxt[NCH];
    logic [NCH-1:0] arm_r, arm_nxt, cap_r, cap_nxt, mbr_nxt, enp_r, rdy, go;
    sofs_rxw_s [NCH-1:0] out_r, out_nxt;
    logic [NCH-1:0] vld_r, vld_nxt;

    always_comb begin
        for (int i = 0; i < NCH; i++)
            rdy[i] = !(arm_r[i] && lane_en_r[i] && !cap_r[i]);
        for (int i = 0; i < NCH; i++) begin
            go[i] = cap_r[i];
            for (int j = 0; j < NCH; j++)
                if (same_grp(i, j, ctrl_r[`SOFS_B_GRP +: 2]))
                    go[i] = go[i] && rdy[j];
            arm_nxt[i] = arm_r[i];
            cap_nxt[i] = cap_r[i];
            fs_nxt[i] = fs_r[i];
            mbr_nxt[i] = mbr_r[i];
            dly_nxt[i] = dly_r[i];
            rp_nxt[i] = rp_r[i] + AW'(1);
            if (realign_r) begin
                arm_nxt[i] = lane_en_r[i];
                cap_nxt[i] = 1'b0;
            end else if (go[i]) begin
                rp_nxt[i] = fs_r[i];
                dly_nxt[i] = wp_r + AW'(1) - fs_r[i];
                mbr_nxt[i] = lane_en_r[i];
                arm_nxt[i] = 1'b0;
                cap_nxt[i] = 1'b0;
            end else if (arm_r[i] && !cap_r[i] && fw_w[i].fp) begin
                cap_nxt[i] = 1'b1;
                fs_nxt[i] = wp_r;
            end
            if (!realign_r && !go[i] && lane_en_r[i] && !enp_r[i] && mbr_r[i])
                rp_nxt[i] = wp_r + AW'(1) - dly_r[i];
            if (bypass_r[i]) begin
                out_nxt[i] = fw_w[i];
                vld_nxt[i] = fv_w[i];
            end else begin
                out_nxt[i] = (mbr_r[i] && lane_en_r[i]) ? mem[i][rp_r[i]] : '0;
                vld_nxt[i] = mbr_r[i] && lane_en_r[i];
            end
        end
    end

    always_ff @(posedge pclk) begin
        for (int i = 0; i < NCH; i++)
            mem[i][wp_r] <= fw_w[i];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wp_r <= '0;
            arm_r <= '0;
            cap_r <= '0;
            mbr_r <= '0;
            enp_r <= '0;
            out_r <= '0;
            vld_r <= '0;
            for (int i = 0; i < NCH; i++) begin
                fs_r[i] <= '0;
                rp_r[i] <= '0;
                dly_r[i] <= '0;
            end
        end else begin
            wp_r <= wp_r + AW'(1);
            arm_r <= arm_nxt;
            cap_r <= cap_nxt;
            mbr_r <= mbr_nxt;
            enp_r <= lane_en_r;
            out_r <= out_nxt;
            vld_r <= vld_nxt;
            fs_r <= fs_nxt;
            rp_r <= rp_nxt;
            dly_r <= dly_nxt;
        end
    end

    assign rx_word = out_r;
    assign rx_vld = vld_r;
endmodule : sofs_top

/* File: testbench/sofs_line_model.sv */
// Line side model: loops tx_line back to rx_line.
// Assumes same clock; lanes above 0 arrive one word later and one byte off.
`timescale 1ns/1ps
module sofs_line_model #(
    parameter int NCH = 2
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [NCH-1:0][31:0] tx_line,
    output logic [NCH-1:0][31:0] rx_line
);
    logic [NCH-1:0][31:0] d0_r, d0_nxt, d1_r, d1_nxt;
    always_comb begin
        d0_nxt = tx_line;
        d1_nxt = d0_r;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            d0_r <= '0;
            d1_r <= '0;
        end else begin
            d0_r <= d0_nxt;
            d1_r <= d1_nxt;
        end
    end
    // Skew and byte slip for the framer to undo
    always_comb begin
        for (int l = 0; l < NCH; l++) begin
            rx_line[l] = (l == 0) ? d0_r[l] : {d1_r[l][23:0], d0_r[l][31:24]};
        end
    end
endmodule : sofs_line_model

/* File: testbench/sofs_chk_sva.sv */
// Port checks for the framer/scrambler top.
// Assumes one clock pclk, active-low asynchronous presetn.
`timescale 1ns/1ps
`include "sofs_defines.svh"
module sofs_chk import sofs_pkg::*; #(
    parameter int NCH = 8,
    parameter int ROW_WORDS = 1080
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic tx_sof,
    input wire logic [NCH-1:0][31:0] tx_line,
    input wire sofs_rxw_s [NCH-1:0] rx_word,
    input wire logic [NCH-1:0] rx_vld,
    input wire logic [NCH-1:0] oof_evt
);
    localparam int FRAME = 9 * ROW_WORDS;
    logic [11:0] ctrl_r, ctrl_nxt;
    logic [15:0] gap_r, gap_nxt;
    logic wr_ctrl, unmapped;
    assign wr_ctrl = psel && penable && pwrite && pready && paddr == 12'h000;
    assign unmapped = !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00c, 12'h010});
    always_comb begin
        ctrl_nxt = wr_ctrl ? pwdata[11:0] : ctrl_r;
        gap_nxt = tx_sof ? 16'h0 : gap_r + 16'h1;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= {1'b0, `SOFS_CTRL_RST};
            gap_r <= 16'h0;
        end else begin
            ctrl_r <= ctrl_nxt;
            gap_r <= gap_nxt;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence acc_s;
        psel && penable;
    endsequence
    sequence sof_auto_s;
        tx_sof && ctrl_r[`SOFS_B_AUTOMATIC_OVERHEAD_INSERT];
    endsequence
    apb_ready_a: assert property (acc_s |-> pready)
        else $error("pready low in access");
    apb_err_a: assert property (acc_s |-> pslverr == unmapped)
        else $error("pslverr wrong for address");
    frame_len_a: assert property (tx_sof && gap_r != 16'h0 |-> gap_r == 16'(FRAME - 1))
        else $error("frame length wrong");
    sof_pulse_a: assert property (tx_sof |=> !tx_sof)
        else $error("tx_sof longer than one cycle");
    auto_a1_a: assert property (sof_auto_s ##0 !ctrl_r[`SOFS_B_CORR_A] |=>
        tx_line[0] == {4{`SOFS_A1}}) else $error("auto A1 word wrong");
    corr_a1_a: assert property (sof_auto_s ##0 ctrl_r[`SOFS_B_CORR_A] |=>
        tx_line[0] == ~{4{`SOFS_A1}}) else $error("corrupted A1 word wrong");
    fp_pulse_a: assert property (rx_word[0].fp |=> !rx_word[0].fp)
        else $error("frame pulse too long");
    fp_first_a: assert property (rx_word[0].fp |-> rx_vld[0] && !rx_word[0].spe)
        else $error("frame pulse not on first word");
    spe_oh_a: assert property (rx_vld[0] && $fell(rx_word[0].spe) |->
        (!rx_word[0].spe) [*8]) else $error("payload flag back too soon");
    oof_pulse_a: assert property (oof_evt[0] |=> !oof_evt[0])
        else $error("out of frame event too long");
endmodule : sofs_chk
bind sofs_top sofs_chk #(.NCH(NCH), .ROW_WORDS(ROW_WORDS)) i_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .tx_sof(tx_sof),
    .tx_line(tx_line), .rx_word(rx_word), .rx_vld(rx_vld), .oof_evt(oof_evt)
);

/* File: testbench/sonet_overhead_framer_scrambler_test.sv */
// Bench: register table, looped-back traffic, fault injection, alarms.
// Assumes sofs_line_model closes the line side.
`timescale 1ns/1ps
`include "sofs_defines.svh"
module sonet_overhead_framer_scrambler_test import sofs_pkg::*;;
    localparam int NCH = 2;
    localparam int ROW = 64;
    localparam int TOH = 36;
    localparam int FRAME = 9 * ROW;
    typedef struct {logic w; logic [11:0] a; logic [31:0] d; logic e;} sofs_row_s;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, tx_sof, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [NCH-1:0][31:0] tx_data, tx_line, rx_line;
    sofs_rxw_s [NCH-1:0] rx_word;
    logic [NCH-1:0] rx_vld, oof_evt;
    logic mon_on = 1'b0;
    int fail_count = 0, checks_done = 0, pos = 0, rpos = -1, oof_n = 0;
    sofs_row_s rows [10] = '{'{1'b0, 12'h000, 32'h1e0, 1'b0}, '{1'b0, 12'h004, 32'h3, 1'b0},
        '{1'b0, 12'h008, 32'h0, 1'b0}, '{1'b0, 12'h010, 32'h0, 1'b0},
        '{1'b0, 12'h014, 32'h0, 1'b1}, '{1'b1, 12'h014, 32'hffffffff, 1'b1},
        '{1'b0, 12'h000, 32'h1e0, 1'b0}, '{1'b1, 12'h008, 32'h3, 1'b0},
        '{1'b0, 12'h008, 32'h3, 1'b0}, '{1'b1, 12'h008, 32'h0, 1'b0}};
    sofs_top #(.NCH(NCH), .ROW_WORDS(ROW), .TOH_WORDS(TOH), .DEPTH(16)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tx_data(tx_data), .tx_sof(tx_sof), .tx_line(tx_line), .rx_line(rx_line),
        .rx_word(rx_word), .rx_vld(rx_vld), .oof_evt(oof_evt));
    sofs_line_model #(.NCH(NCH)) i_line (.pclk(pclk), .presetn(presetn),
        .tx_line(tx_line), .rx_line(rx_line));
    function automatic logic [31:0] pat(int p, int l);
        if (p < 12) return {4{`SOFS_A1}};
        if (p < 24) return {4{`SOFS_A2}};
        return {8'(l), 8'h3c, 16'(p)};
    endfunction : pat
    task automatic chk32(input string n, input logic [31:0] x, input logic [31:0] g);
        checks_done++;
        if (g !== x) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, x, g);
        end
    endtask : chk32
    task automatic chk1(input string n, input logic x, input logic g);
        checks_done++;
        if (g !== x) begin
            fail_count++;
            $display("ERROR %s expected %b seen %b", n, x, g);
        end
    endtask : chk1
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic frames(input int n);
        repeat (n * FRAME) @(posedge pclk);
    endtask : frames
    task automatic chk_tx(input logic [7:0] inv);
        repeat (2 * FRAME) begin
            @(negedge pclk);
            if (tx_sof === 1'b1) break;
        end
        for (int j = 0; j <= TOH; j++) begin
            @(negedge pclk);
            if (j == 0) chk32("tx_a1", {4{`SOFS_A1 ^ inv}}, tx_line[0]);
            if (j == 12) chk32("tx_a2", {4{`SOFS_A2 ^ inv}}, tx_line[0]);
            if (j == TOH) chk32("tx_scr", pat(TOH, 0) ^ 32'hfe041851, tx_line[0]);
        end
    endtask : chk_tx
    task complete_run;
        if (fail_count == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : complete_run
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        pos <= tx_sof ? 1 : (pos + 1) % FRAME;
        for (int l = 0; l < NCH; l++) tx_data[l] <= pat(tx_sof ? 1 : (pos + 1) % FRAME, l);
    end
    always @(negedge pclk) begin
        if (oof_evt[0] === 1'b1) oof_n++;
        if (!mon_on) rpos = -1;
        else if (rx_vld[0] === 1'b1) begin
            if (rx_word[0].fp === 1'b1) rpos = 0;
            else if (rpos >= 0) rpos++;
            for (int l = 0; l < NCH && rpos >= 0; l++) begin
                chk1("rx_vld", 1'b1, rx_vld[l]);
                chk1("rx_fp", rx_word[0].fp, rx_word[l].fp);
                chk1("rx_spe", (rpos % ROW) >= TOH, rx_word[l].spe);
                if (rx_word[l].spe === 1'b1) chk32("rx_data", pat(rpos, l), rx_word[l].data);
            end
        end
    end
    initial begin
        repeat (40000) @(posedge pclk);
        fail_count++;
        complete_run;
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        tx_data = '0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            chk1("apb_err", rows[i].e, e);
            if (!rows[i].w) chk32("apb_rd", rows[i].d, q);
        end
        apb(1'b1, 12'h000, 32'hbe1);
        frames(3);
        apb(1'b1, 12'h000, 32'hbe1);
        apb(1'b0, 12'h000, 32'h0);
        chk32("ctrl_realign", 32'h3e1, q);
        frames(2);
        mon_on = 1'b1;
        chk_tx(8'h00);
        apb(1'b0, 12'h00c, 32'h0);
        chk32("status", 32'h303, q);
        apb(1'b1, 12'h010, 32'hffffffff);
        frames(2);
        apb(1'b0, 12'h010, 32'h0);
        chk32("alarm_clean", 32'h0, q);
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, 12'h000, k ? 32'h3f1 : 32'h3e9);
            frames(2);
            apb(1'b0, 12'h010, 32'h0);
            chk32("alarm_flag", k ? 32'h03000000 : 32'h00000300, q);
            apb(1'b1, 12'h000, 32'h3e1);
            frames(1);
            apb(1'b1, 12'h010, 32'hffffffff);
        end
        mon_on = 1'b0;
        apb(1'b1, 12'h004, 32'h1);
        frames(1);
        chk1("rx_off", 1'b0, rx_vld[1]);
        apb(1'b1, 12'h004, 32'h3);
        @(posedge pclk);
        mon_on = 1'b1;
        frames(1);
        mon_on = 1'b0;
        apb(1'b1, 12'h000, 32'h3e5);
        oof_n = 0;
        chk_tx(8'hff);
        frames(6);
        chk32("oof_count", 32'h1, oof_n);
        apb(1'b0, 12'h010, 32'h0);
        chk32("alarm_oof", 32'h00030003, q & 32'h00ff00ff);
        apb(1'b0, 12'h00c, 32'h0);
        chk32("status_oof", 32'h0, q & 32'hff);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h000, 32'h0);
        chk32("ctrl_rst", 32'h1e0, q);
        complete_run;
    end
endmodule : sonet_overhead_framer_scrambler_test
